// >>> rtl/rtca_regs.v
// Register file of the real-time clock: control, alarms, stopwatch, time, calendar, events.
// Contract
// RULE1 - Trim value field is write-only and always reads zero.
// RULE2 - Writing soft reset 1 clears counter hold and thirty-second adjust.
// RULE3 - Soft reset write clears the eight divider tap status bits.
// RULE4 - Flags set by hardware events; cleared only by writing 1.
// RULE5 - Separate flag and enable bits for thirteen listed events.
// RULE6 - Stopwatch soft reset reads zero and resets the stopwatch count.
// RULE7 - Stopwatch tenths and hundredths BCD digits are read-only, reset zero.
// RULE8 - Hour resets to 12 BCD; minutes and PM reset zero.
// RULE9 - Calendar resets to month 01, day 01; year and weekday zero.
// RULE10 - Trim-busy and update-busy read-only status bits, zero after reset.
// RULE11 - Alarm registers hold BCD digits in the time register layout.
// RULE12 - Year two BCD digits, weekday three bits, upper five reserved.
// RULE13 - Interrupt asserted while any enabled flag is set.
// RULE14 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "rtca_defs.vh"
module rtca_regs #(
  parameter AW = `RTCA_AW,
  parameter DW = `RTCA_DW
) (
  input  wire          clk_sys,
  input  wire          arst_n,
  input  wire [AW-1:0] reg_addr,
  input  wire [DW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [DW-1:0] reg_rdata,
  input  wire [7:0]    divider_taps,
  input  wire [7:0]    stopwatch_digits,
  input  wire          counter_update_pending,
  input  wire          trim_in_progress,
  input  wire [15:0]   event_pulses,
  output reg  [6:0]    trim_value,
  output reg           trim_load,
  output reg           clock_run,
  output reg           counter_hold,
  output reg           twenty_four_hour_select,
  output reg           thirty_second_adjust,
  output reg           clock_soft_reset,
  output reg           stopwatch_run,
  output reg           stopwatch_soft_reset,
  output reg  [15:0]   alarm_sec_reg,
  output reg  [15:0]   alarm_hm_reg,
  output reg  [15:0]   time_sec_reg,
  output reg  [15:0]   time_hm_reg,
  output reg  [15:0]   date_reg,
  output reg  [15:0]   year_reg,
  output wire          irq
);
  // One compare serves every register write hit, so all write decodes stay alike.
  function addr_is;
    input [AW-1:0] addr;
    input [AW-1:0] offset;
    begin
      addr_is = (addr == offset);
    end
  endfunction

  // Time and calendar registers hold software's view; only bus writes load them, and the counting engine reads them.
  wire        wr_ctl   = reg_wr && addr_is(reg_addr, `RTCA_OFF_CTL);
  wire        wr_sw    = reg_wr && addr_is(reg_addr, `RTCA_OFF_SWCTL);
  wire        wr_intf  = reg_wr && addr_is(reg_addr, `RTCA_OFF_INTF);
  wire        wr_inte  = reg_wr && addr_is(reg_addr, `RTCA_OFF_INTE);
  wire        srst_now = wr_ctl && reg_wdata[`RTCA_CTL_SRST];
  wire [15:0] flags;
  wire [15:0] enables;
  reg  [7:0]  taps;
  reg  [7:0]  sw_digits;
  reg  [15:0] next_rdata;

  rtca_event_flags #(
    .W(16)
  ) u_flags (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .event_set   (event_pulses & `RTCA_EVT_MASK), // [RULE5]
    .clear_mask  (wr_intf ? reg_wdata : `RTCA_ZERO16), // [RULE4]
    .enable_wr   (wr_inte),
    .enable_data (reg_wdata),
    .valid_mask  (`RTCA_EVT_MASK),
    .flags       (flags),
    .enables     (enables),
    .irq         (irq)
  );

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trim_value              <= 7'h00;
      trim_load               <= 1'b0;
      clock_run               <= 1'b0;
      counter_hold            <= 1'b0;
      twenty_four_hour_select <= 1'b0;
      thirty_second_adjust    <= 1'b0;
      clock_soft_reset        <= 1'b0;
      stopwatch_run           <= 1'b0;
      stopwatch_soft_reset    <= 1'b0;
      alarm_sec_reg           <= `RTCA_ZERO16;
      alarm_hm_reg            <= `RTCA_ZERO16;
      time_sec_reg            <= `RTCA_ZERO16;
      time_hm_reg             <= `RTCA_HUR_RESET; // [RULE8]
      date_reg                <= `RTCA_MON_RESET; // [RULE9]
      year_reg                <= `RTCA_ZERO16;
      taps                    <= 8'h00;
      sw_digits               <= 8'h00;
      reg_rdata               <= `RTCA_ZERO16;
    end else begin
      trim_load            <= wr_ctl;
      stopwatch_soft_reset <= wr_sw && reg_wdata[`RTCA_SW_SRST]; // [RULE6]
      if (wr_ctl) begin
        trim_value              <= reg_wdata[`RTCA_TRIM_HI:`RTCA_TRIM_LO];
        clock_run               <= reg_wdata[`RTCA_CTL_RUN];
        twenty_four_hour_select <= reg_wdata[`RTCA_CTL_24H];
        clock_soft_reset        <= reg_wdata[`RTCA_CTL_SRST];
        // Soft reset overrides whatever is written to hold and adjust.
        counter_hold         <= reg_wdata[`RTCA_CTL_HLD] & ~srst_now; // [RULE2]
        thirty_second_adjust <= reg_wdata[`RTCA_CTL_ADJ] & ~srst_now; // [RULE2]
      end
      if (srst_now)
        taps <= 8'h00; // [RULE3]
      else
        taps <= divider_taps;
      if (wr_sw) begin
        stopwatch_run <= reg_wdata[`RTCA_SW_RUN];
      end
      if (wr_sw && reg_wdata[`RTCA_SW_SRST])
        sw_digits <= 8'h00; // [RULE6] [RULE7]
      else
        sw_digits <= stopwatch_digits;
      if (reg_wr && addr_is(reg_addr, `RTCA_OFF_ALM_SEC))
        alarm_sec_reg <= reg_wdata & `RTCA_ALM_SEC_MASK; // [RULE11] [RULE14]
      if (reg_wr && addr_is(reg_addr, `RTCA_OFF_ALM_HM))
        alarm_hm_reg <= reg_wdata & `RTCA_HM_MASK; // [RULE11]
      if (reg_wr && addr_is(reg_addr, `RTCA_OFF_SEC))
        time_sec_reg <= reg_wdata & `RTCA_ALM_SEC_MASK;
      if (reg_wr && addr_is(reg_addr, `RTCA_OFF_HUR))
        time_hm_reg <= reg_wdata & `RTCA_HM_MASK;
      if (reg_wr && addr_is(reg_addr, `RTCA_OFF_MON))
        date_reg <= reg_wdata & `RTCA_MON_MASK;
      if (reg_wr && addr_is(reg_addr, `RTCA_OFF_YAR))
        year_reg <= reg_wdata & `RTCA_YAR_MASK; // [RULE12]
      reg_rdata <= reg_rd ? next_rdata : `RTCA_ZERO16;
    end
  end

  always @* begin
    next_rdata = `RTCA_ZERO16;
    case (reg_addr)
      `RTCA_OFF_CTL: begin
        // Trim field bits 14:8 stay zero on read.
        next_rdata[`RTCA_CTL_TRMBSY] = trim_in_progress; // [RULE1] [RULE10]
        next_rdata[`RTCA_CTL_BSY]    = counter_update_pending; // [RULE10]
        next_rdata[`RTCA_CTL_HLD]    = counter_hold;
        next_rdata[`RTCA_CTL_24H]    = twenty_four_hour_select;
        next_rdata[`RTCA_CTL_ADJ]    = thirty_second_adjust;
        next_rdata[`RTCA_CTL_SRST]   = clock_soft_reset;
        next_rdata[`RTCA_CTL_RUN]    = clock_run;
      end
      `RTCA_OFF_ALM_SEC: next_rdata = alarm_sec_reg;
      `RTCA_OFF_ALM_HM:  next_rdata = alarm_hm_reg;
      `RTCA_OFF_SWCTL: begin
        next_rdata[`RTCA_SWDIG_HI:`RTCA_SWDIG_LO] = sw_digits; // [RULE7]
        next_rdata[`RTCA_SW_RUN] = stopwatch_run; // [RULE6]
      end
      `RTCA_OFF_SEC:  next_rdata = time_sec_reg | {8'h00, taps};
      `RTCA_OFF_HUR:  next_rdata = time_hm_reg;
      `RTCA_OFF_MON:  next_rdata = date_reg;
      `RTCA_OFF_YAR:  next_rdata = year_reg;
      `RTCA_OFF_INTF: next_rdata = flags;
      `RTCA_OFF_INTE: next_rdata = enables;
      default:        next_rdata = `RTCA_ZERO16; // [RULE14]
    endcase
  end
endmodule // rtca_regs
`default_nettype wire

// >>> rtl/rtca_defs.vh
// Register offsets, field positions and reset values of the real-time clock block.
`ifndef RTCA_DEFS_VH
`define RTCA_DEFS_VH
`define RTCA_AW              16
`define RTCA_DW              16
`define RTCA_OFF_CTL         16'h40c0
`define RTCA_OFF_ALM_SEC     16'h40c2
`define RTCA_OFF_ALM_HM      16'h40c4
`define RTCA_OFF_SWCTL       16'h40c6
`define RTCA_OFF_SEC         16'h40c8
`define RTCA_OFF_HUR         16'h40ca
`define RTCA_OFF_MON         16'h40cc
`define RTCA_OFF_YAR         16'h40ce
`define RTCA_OFF_INTF        16'h40d0
`define RTCA_OFF_INTE        16'h40d2
`define RTCA_CTL_RUN         0
`define RTCA_CTL_SRST        1
`define RTCA_CTL_ADJ         2
`define RTCA_CTL_24H         4
`define RTCA_CTL_HLD         5
`define RTCA_CTL_BSY         6
`define RTCA_CTL_TRMBSY      15
`define RTCA_SW_RUN          0
`define RTCA_SW_SRST         4
`define RTCA_TRIM_HI         14
`define RTCA_TRIM_LO         8
`define RTCA_SWDIG_HI        15
`define RTCA_SWDIG_LO        8
`define RTCA_EVT_MASK        16'hf1ff
`define RTCA_ALM_SEC_MASK    16'h7f00
`define RTCA_HM_MASK         16'h7f7f
`define RTCA_MON_MASK        16'h1f3f
`define RTCA_YAR_MASK        16'h07ff
`define RTCA_HUR_RESET       16'h1200
`define RTCA_MON_RESET       16'h0101
`define RTCA_EVT_1_32        0
`define RTCA_EVT_1_8         1
`define RTCA_EVT_1_4         2
`define RTCA_EVT_1_2         3
`define RTCA_EVT_SEC         4
`define RTCA_EVT_MIN         5
`define RTCA_EVT_HOUR        6
`define RTCA_EVT_DAY         7
`define RTCA_EVT_ALARM       8
`define RTCA_EVT_SW100       12
`define RTCA_EVT_SW10        13
`define RTCA_EVT_SW1         14
`define RTCA_EVT_TRIM        15
`define RTCA_ZERO16          16'h0000
`endif

// >>> rtl/rtca_event_flags.v
// Sticky event flags with write-one-to-clear, enable mask and level interrupt.
`timescale 1ns/1ps
`default_nettype none
module rtca_event_flags #(
  parameter W = 16
) (
  input  wire         clk_sys,
  input  wire         arst_n,
  input  wire [W-1:0] event_set,
  input  wire [W-1:0] clear_mask,
  input  wire         enable_wr,
  input  wire [W-1:0] enable_data,
  input  wire [W-1:0] valid_mask,
  output reg  [W-1:0] flags,
  output reg  [W-1:0] enables,
  output reg          irq
);
  wire [W-1:0] next_flags;
  wire [W-1:0] next_enables;

  // A set in the same cycle as its clear wins, so no event is lost.
  assign next_flags   = ((flags & ~clear_mask) | event_set) & valid_mask; // [RULE4] [RULE14]
  assign next_enables = enable_wr ? (enable_data & valid_mask) : enables; // [RULE14]

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags   <= {W{1'b0}};
      enables <= {W{1'b0}};
      irq     <= 1'b0;
    end else begin
      flags   <= next_flags;
      enables <= next_enables;
      irq     <= |(next_flags & next_enables); // [RULE13]
    end
  end
endmodule // rtca_event_flags
`default_nettype wire

// >>> sim/rtca_regs_properties.sv
// Checker of the register-port behaviour of the real-time clock register file.
`timescale 1ns/1ps
`default_nettype none
`include "rtca_defs.vh"
module rtca_regs_props (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        counter_hold,
  input wire logic        thirty_second_adjust,
  input wire logic        stopwatch_soft_reset,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_trim_rd0; reg_rd && reg_addr == `RTCA_OFF_CTL |=> reg_rdata[14:8] == 7'h00; endproperty
  a_trim_rd0: assert property (p_trim_rd0) else $error("trim field read nonzero");
  property p_srst_clr;
    reg_wr && reg_addr == `RTCA_OFF_CTL && reg_wdata[1] |=> !counter_hold && !thirty_second_adjust;
  endproperty
  a_srst_clr: assert property (p_srst_clr) else $error("hold or adjust kept");
  property p_sw_rd0; reg_rd && reg_addr == `RTCA_OFF_SWCTL |=> reg_rdata[7:1] == 7'h00; endproperty
  a_sw_rd0: assert property (p_sw_rd0) else $error("stopwatch reset bit read");
  property p_sw_pulse; reg_wr && reg_addr == `RTCA_OFF_SWCTL && reg_wdata[4] |=> stopwatch_soft_reset;
  endproperty
  a_sw_pulse: assert property (p_sw_pulse) else $error("no stopwatch reset pulse");
  property p_sw_cause;
    stopwatch_soft_reset |-> $past(reg_wr) && $past(reg_addr) == `RTCA_OFF_SWCTL && $past(reg_wdata[4]);
  endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("stray stopwatch reset");
  property p_evt_rsv; reg_rd && reg_addr == `RTCA_OFF_INTF |=> reg_rdata[11:9] == 3'h0; endproperty
  a_evt_rsv: assert property (p_evt_rsv) else $error("reserved flag bits set");
  property p_unmapped; reg_rd && reg_addr == 16'h40d4 |=> reg_rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  // A falling request needs a register write one or two cycles before it.
  property p_irq_fall; $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
  c_srst: cover property (reg_wr && reg_addr == `RTCA_OFF_CTL && reg_wdata[1]);
  c_stopwatch_soft_reset: cover property (stopwatch_soft_reset);
  c_irq: cover property ($rose(irq));
endmodule // rtca_regs_props
bind rtca_regs rtca_regs_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .counter_hold(counter_hold), .thirty_second_adjust(thirty_second_adjust),
  .stopwatch_soft_reset(stopwatch_soft_reset), .irq(irq));
`default_nettype wire

// >>> sim/tb_rtca_regs.sv
// Self-checking bench of the real-time clock register file.
`timescale 1ns/1ps
`default_nettype none
`include "rtca_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_rtca_regs;
  logic        clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        cup = 1'b0, tbsy = 1'b0, irq;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, ev = 16'h0000, reg_rdata, d;
  logic [7:0]  taps = 8'h00, digs = 8'h00;
  logic [6:0]  trim_value;
  logic        trim_load, clock_run, twenty_four_hour_select, clock_soft_reset;
  logic        stopwatch_run, stopwatch_soft_reset, counter_hold, thirty_second_adjust;
  logic [15:0] alarm_sec_reg, alarm_hm_reg, time_sec_reg, time_hm_reg, date_reg, year_reg, q;
  logic [15:0] rw_addr [8] = '{16'h40c2, 16'h40c4, 16'h40ca, 16'h40cc, 16'h40ce, 16'h40d2,
                              16'h40c8, 16'h40d4};
  integer      error_cnt = 0, compares = 0, seed = 32'h57f9, cyc = 0, i, j;
  rtca_regs dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .divider_taps(taps), .stopwatch_digits(digs), .counter_update_pending(cup),
    .trim_in_progress(tbsy), .event_pulses(ev), .trim_value(trim_value),
    .trim_load(trim_load), .clock_run(clock_run), .counter_hold(counter_hold),
    .twenty_four_hour_select(twenty_four_hour_select),
    .thirty_second_adjust(thirty_second_adjust), .clock_soft_reset(clock_soft_reset),
    .stopwatch_run(stopwatch_run), .stopwatch_soft_reset(stopwatch_soft_reset),
    .alarm_sec_reg(alarm_sec_reg), .alarm_hm_reg(alarm_hm_reg), .time_sec_reg(time_sec_reg),
    .time_hm_reg(time_hm_reg), .date_reg(date_reg), .year_reg(year_reg), .irq(irq));
  always #12.5 clk_sys = ~clk_sys;
  // Seconds read back merged with the live divider taps, so taps join the expectation.
  function logic [15:0] exp_rw(input logic [15:0] a, v);
    case (a)
      16'h40c2: exp_rw = v & 16'h7f00;
      16'h40c4, 16'h40ca: exp_rw = v & 16'h7f7f;
      16'h40cc: exp_rw = v & 16'h1f3f;
      16'h40ce: exp_rw = v & 16'h07ff;
      16'h40d2: exp_rw = v & 16'hf1ff;
      16'h40c8: exp_rw = (v & 16'h7f00) | {8'h00, taps};
      default: exp_rw = 16'h0000;
    endcase
  endfunction
  // Register outputs as the time engine sees them; seconds carry the taps like a read.
  function logic [15:0] out_of(input logic [15:0] a);
    case (a)
      16'h40c2: out_of = alarm_sec_reg;
      16'h40c4: out_of = alarm_hm_reg;
      16'h40c8: out_of = time_sec_reg | {8'h00, taps};
      16'h40ca: out_of = time_hm_reg;
      16'h40cc: out_of = date_reg;
      16'h40ce: out_of = year_reg;
      default: out_of = 16'h0000;
    endcase
  endfunction
  // Read issued in the edge step where a write task returned, so strobes run back to back.
  task rd_now(input logic [15:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task bus_wr(input logic [15:0] a, v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task bus_rd(input logic [15:0] a, e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task end_of_test;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (i = 0; i < 10; i++) bus_rd(16'h40c0 + 2 * i, i == 5 ? 16'h1200 : i == 6 ? 16'h0101 : 16'h0000);
    `CHK({time_hm_reg, date_reg}, 32'h12000101)
    @(posedge clk_sys);
    taps <= $random(seed) | 8'h80;
    digs <= 8'h59;
    cup <= 1'b1;
    tbsy <= 1'b1;
    for (j = 0; j < 3; j++) for (i = 0; i < 8; i++) begin
      d = $random(seed);
      bus_wr(rw_addr[i], d);
      bus_rd(rw_addr[i], exp_rw(rw_addr[i], d));
      if (i != 5 && i != 7) `CHK(out_of(rw_addr[i]), exp_rw(rw_addr[i], d))
    end
    d = $random(seed) & 16'hfffd;
    bus_wr(`RTCA_OFF_CTL, d);
    #1 `CHK({trim_value, trim_load, clock_run}, {d[14:8], 1'b1, d[0]})
    bus_rd(`RTCA_OFF_CTL, (d & 16'h0035) | 16'h8040);
    bus_wr(`RTCA_OFF_CTL, 16'h7f27);
    rd_now(`RTCA_OFF_SEC);
    `CHK(q[7:0], 8'h00)
    bus_rd(`RTCA_OFF_CTL, 16'h8043);
    bus_wr(`RTCA_OFF_SWCTL, 16'hffff);
    rd_now(`RTCA_OFF_SWCTL);
    `CHK({q, stopwatch_run}, {16'h0001, 1'b1})
    bus_rd(`RTCA_OFF_SWCTL, 16'h5901);
    bus_wr(`RTCA_OFF_INTE, 16'h0000);
    bus_wr(`RTCA_OFF_INTF, 16'hffff);
    d = $random(seed) | 16'h8101;
    @(posedge clk_sys) ev <= d;
    @(posedge clk_sys) ev <= 16'h0000;
    bus_rd(`RTCA_OFF_INTF, d & 16'hf1ff);
    bus_wr(`RTCA_OFF_INTF, 16'h0000);
    bus_rd(`RTCA_OFF_INTF, d & 16'hf1ff);
    bus_wr(`RTCA_OFF_INTF, d & 16'h00ff);
    bus_rd(`RTCA_OFF_INTF, d & 16'hf100);
    bus_wr(`RTCA_OFF_INTE, 16'h8000);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irq, 1'b1)
    bus_wr(`RTCA_OFF_INTE, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irq, 1'b0)
    end_of_test;
  end
endmodule // tb_rtca_regs
`default_nettype wire
